// [rtl/nvsq_pkg.sv]
package nvsq_pkg;
   // ****************************************
   // pin widths and magic addresses
   // ****************************************
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam logic [10:0] SEQ_A0 = 11'h000;
   localparam logic [10:0] SEQ_A1 = 11'h555;
   localparam logic [10:0] SEQ_A2 = 11'h2aa;
   localparam logic [10:0] SEQ_A3 = 11'h7ff;
   localparam logic [10:0] SEQ_A4 = 11'h0f0;
   localparam logic [10:0] SEQ_SAVE = 11'h70f;
   localparam logic [10:0] SEQ_LOAD = 11'h70e;
   localparam int SEQ_LEN = 6;
   // ****************************************
   // timing, clk_sys at 50 mhz
   // ****************************************
   localparam int CLK_MHZ = 50;
   localparam int CLK_NS = 20;
   localparam int CYCLE_NS = 45;
   localparam int SAVE_US = 10000;
   localparam int LOAD_US = 20;
   localparam int BOOT_US = 550;
   // least times round up
   localparam int CYCLE_CLKS = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CLKS = CYCLE_CLKS;
   localparam int SAVE_CLKS = SAVE_US * CLK_MHZ;
   localparam int LOAD_CLKS = LOAD_US * CLK_MHZ;
   localparam int BOOT_CLKS = BOOT_US * CLK_MHZ;
   localparam int CNT_W = 20;
   // ****************************************
   // user commands
   // ****************************************
   typedef enum logic [1:0] {
      nvsq_cmd_read,
      nvsq_cmd_write,
      nvsq_cmd_save,
      nvsq_cmd_load
   } nvsq_cmd_e;
endpackage

// [rtl/nvsq_timer.sv]
`timescale 1ns/1ps
module nvsq_timer #(
   parameter int CNT_W = 20
) (
   input wire logic clk_sys, // system clock
   input wire logic rst, // async reset
   input wire logic load, // start pulse
   input wire logic [CNT_W-1:0] count, // cycles to wait
   output logic done // high when idle
);
   logic [CNT_W-1:0] cnt_ff;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_ff <= '0;
      end else if (load) begin
         cnt_ff <= count;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end
   assign done = (cnt_ff == '0) && !load;
endmodule // nvsq_timer

// [rtl/nvsq_host.sv]
`timescale 1ns/1ps
// What this block does
// - update_n is driven high for every read and low for every write.
// - a save is six cs_n reads at 000, 555, 2aa, 7ff, 0f0 and 70f in that order.
// - a load is six cs_n reads at 000, 555, 2aa, 7ff, 0f0 and 70e in that order.
// - update_n stays high across all six sequence accesses.
// - each sequence access is a cs_n low pulse, not an address change alone.
// - each sequence access lasts at least the slowest grade's cycle time.
// - nothing else is issued between sequence accesses, so no abort occurs.
module nvsq_host #(
   parameter int SAVE_CLKS = nvsq_pkg::SAVE_CLKS, // save wait in cycles
   parameter int BOOT_CLKS = nvsq_pkg::BOOT_CLKS // power-up wait in cycles
) (
   input wire logic clk_sys, // 50 mhz clock
   input wire logic rst, // async reset, high
   input wire logic req_valid, // command request
   input wire logic [1:0] req_cmd, // nvsq_cmd_e code
   input wire logic [10:0] req_addr, // byte address
   input wire logic [7:0] req_wdata, // write data
   input wire logic supply_ok, // supply above trip level
   output logic req_ready, // may take a request
   output logic rsp_valid, // read data pulse
   output logic [7:0] rsp_rdata, // read data
   output logic busy, // device unreachable
   output logic save_refused, // save dropped, low supply
   output logic cs_n, // chip select, low
   output logic update_n, // write strobe, low
   output logic oe_n, // output gate, low
   output logic [10:0] addr, // address pins
   output logic [7:0] dq_o, // data out
   output logic dq_oe, // data drive enable
   input wire logic [7:0] dq_i // data in
);
   // ****************************************
   // checks and sync
   // ****************************************
   // refused at elaboration: save, power-up or load wait counts the timer cannot hold
   if (SAVE_CLKS >= (1 << nvsq_pkg::CNT_W) || BOOT_CLKS >= (1 << nvsq_pkg::CNT_W) ||
      nvsq_pkg::LOAD_CLKS >= (1 << nvsq_pkg::CNT_W)) begin : g_bad_wait
      $error("wait count too wide for timer");
   end
   // a zero pulse count would never drop cs_n
   if (nvsq_pkg::PULSE_CLKS < 1 || nvsq_pkg::PULSE_CLKS > 15) begin : g_bad_pulse
      $error("pulse count outside tick counter range");
   end

   logic [7:0] dq_s1_ff, dq_s2_ff;
   logic sup_s1_ff, sup_s2_ff;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dq_s1_ff <= 8'h00;
         dq_s2_ff <= 8'h00;
         sup_s1_ff <= 1'b0;
         sup_s2_ff <= 1'b0;
      end else begin
         dq_s1_ff <= dq_i;
         dq_s2_ff <= dq_s1_ff;
         sup_s1_ff <= supply_ok;
         sup_s2_ff <= sup_s1_ff;
      end
   end

   // ****************************************
   // state machine
   // ****************************************
   typedef enum logic [2:0] {
      nvsq_boot, nvsq_idle, nvsq_setup, nvsq_pulse, nvsq_gap, nvsq_wait
   } nvsq_state_e;

   nvsq_state_e state_ff;
   logic [3:0] tick_ff;
   logic [2:0] step_ff;
   logic [1:0] cmd_ff;
   logic [10:0] last_ff;
   logic tim_load;
   logic [nvsq_pkg::CNT_W-1:0] tim_count;
   logic tim_done;
   logic boot_go_ff;

   nvsq_timer #(.CNT_W(nvsq_pkg::CNT_W)) u_timer (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(tim_load),
      .count(tim_count),
      .done(tim_done)
   );

   localparam logic [1:0] nvsq_cmd_write_c = 2'(nvsq_pkg::nvsq_cmd_write);
   localparam logic [1:0] nvsq_cmd_save_c = 2'(nvsq_pkg::nvsq_cmd_save);
   localparam logic [1:0] nvsq_cmd_load_c = 2'(nvsq_pkg::nvsq_cmd_load);
   localparam logic [3:0] PULSE_T = 4'(nvsq_pkg::PULSE_CLKS);
   wire seq_cmd = (cmd_ff == nvsq_cmd_save_c) || (cmd_ff == nvsq_cmd_load_c);

   // sequence address for the current step
   function automatic logic [10:0] seq_addr(input logic [2:0] s, input logic [10:0] last);
      case (s)
         3'h0: seq_addr = nvsq_pkg::SEQ_A0;
         3'h1: seq_addr = nvsq_pkg::SEQ_A1;
         3'h2: seq_addr = nvsq_pkg::SEQ_A2;
         3'h3: seq_addr = nvsq_pkg::SEQ_A3;
         3'h4: seq_addr = nvsq_pkg::SEQ_A4;
         default: seq_addr = last;
      endcase
   endfunction

   wire accept = (state_ff == nvsq_idle) && req_valid;
   // save refused on low supply
   wire refuse = accept && (req_cmd == nvsq_cmd_save_c) && !sup_s2_ff;
   // timer load: power-up wait after reset, save or load wait after the sixth sequence access
   assign tim_load = boot_go_ff ||
      ((state_ff == nvsq_gap) && (tick_ff == 4'h0) && seq_cmd && (step_ff == 3'(nvsq_pkg::SEQ_LEN - 1)));
   assign tim_count = boot_go_ff ? nvsq_pkg::CNT_W'(BOOT_CLKS) :
      (cmd_ff == nvsq_cmd_save_c) ? nvsq_pkg::CNT_W'(SAVE_CLKS) :
      nvsq_pkg::CNT_W'(nvsq_pkg::LOAD_CLKS);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         boot_go_ff <= 1'b1;
      end else begin
         boot_go_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff <= nvsq_boot;
         tick_ff <= 4'h0;
         step_ff <= 3'h0;
         cmd_ff <= 2'h0;
         last_ff <= 11'h000;
      end else begin
         case (state_ff)
            nvsq_boot: begin
               if (!boot_go_ff && tim_done) begin
                  state_ff <= nvsq_idle;
               end
            end
            nvsq_idle: begin
               if (accept && !refuse) begin
                  cmd_ff <= req_cmd;
                  step_ff <= 3'h0;
                  last_ff <= (req_cmd == nvsq_cmd_save_c) ? nvsq_pkg::SEQ_SAVE :
                     (req_cmd == nvsq_cmd_load_c) ? nvsq_pkg::SEQ_LOAD : req_addr;
                  state_ff <= nvsq_setup;
               end
            end
            nvsq_setup: begin
               tick_ff <= PULSE_T;
               state_ff <= nvsq_pulse;
            end
            nvsq_pulse: begin
               if (tick_ff == 4'h0) begin
                  tick_ff <= PULSE_T;
                  state_ff <= nvsq_gap;
               end else begin
                  tick_ff <= tick_ff - 4'h1;
               end
            end
            nvsq_gap: begin
               if (tick_ff != 4'h0) begin
                  tick_ff <= tick_ff - 4'h1;
               end else if (seq_cmd && step_ff != 3'(nvsq_pkg::SEQ_LEN - 1)) begin
                  step_ff <= step_ff + 3'h1;
                  state_ff <= nvsq_setup;
               end else if (seq_cmd) begin
                  state_ff <= nvsq_wait;
               end else begin
                  state_ff <= nvsq_idle;
               end
            end
            nvsq_wait: begin
               if (!tim_load && tim_done) begin
                  state_ff <= nvsq_idle;
               end
            end
            default: state_ff <= nvsq_idle;
         endcase
      end
   end

   // ****************************************
   // pins
   // ****************************************
   wire is_wr = (cmd_ff == nvsq_cmd_write_c);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cs_n <= 1'b1;
         update_n <= 1'b1;
         oe_n <= 1'b1;
         addr <= 11'h000;
         dq_o <= 8'h00;
         dq_oe <= 1'b0;
      end else begin
         cs_n <= !(state_ff == nvsq_pulse && tick_ff != 4'h0);
         update_n <= !(is_wr && (state_ff == nvsq_setup || state_ff == nvsq_pulse));
         oe_n <= !(!is_wr && (state_ff == nvsq_setup || state_ff == nvsq_pulse));
         dq_oe <= is_wr && (state_ff == nvsq_setup || state_ff == nvsq_pulse);
         if (state_ff == nvsq_setup) begin
            addr <= seq_cmd ? seq_addr(step_ff, last_ff) : last_ff;
         end
         if (accept) begin
            dq_o <= req_wdata;
         end
      end
   end

   // ****************************************
   // user side
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 8'h00;
         busy <= 1'b1;
         save_refused <= 1'b0;
      end else begin
         req_ready <= (state_ff == nvsq_idle) && !accept;
         busy <= (state_ff == nvsq_boot) || (state_ff == nvsq_wait);
         save_refused <= refuse;
         rsp_valid <= (state_ff == nvsq_gap) && (tick_ff == 4'h0) && !seq_cmd && !is_wr;
         // sequence reads and writes leave the last plain read data in place
         if ((state_ff == nvsq_gap) && (tick_ff == PULSE_T) && !seq_cmd && !is_wr) begin
            rsp_rdata <= dq_s2_ff;
         end
      end
   end
endmodule // nvsq_host

// [verif/nvsq_host_chk_monitor.sv]
`timescale 1ns/1ps
module nvsq_host_chk (
   input wire logic clk_sys, // clock
   input wire logic rst, // reset
   input wire logic rsp_valid, // read pulse
   input wire logic busy, // unreachable
   input wire logic save_refused, // save dropped
   input wire logic cs_n, // select
   input wire logic update_n, // write strobe
   input wire logic oe_n, // output gate
   input wire logic [10:0] addr, // address
   input wire logic dq_oe // drive enable
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_write_float:
   assert property ($fell(cs_n) && !update_n |-> oe_n && !$past(update_n))
      else $error("write selected with gate open");
   chk_access_stable:
   assert property (!cs_n && !$past(cs_n) |-> $stable(addr) && $stable(update_n))
      else $error("address or strobe moved in access");
   chk_pulse_width:
   assert property ($fell(cs_n) |-> !cs_n[*3] ##1 cs_n)
      else $error("select pulse not three cycles");
   chk_gap_width:
   assert property ($rose(cs_n) |-> cs_n[*4])
      else $error("select gap too short");
   chk_no_contention:
   assert property (dq_oe |-> oe_n && !update_n)
      else $error("host drives on a read");
   chk_refuse_quiet:
   assert property (save_refused |-> (cs_n && !busy)[*4])
      else $error("refused save touched the pins");
   chk_busy_idle:
   assert property (busy |-> cs_n)
      else $error("access while device busy");
   chk_seq_last:
   assert property ($rose(busy) |-> update_n && addr[10:1] == 10'h387)
      else $error("busy not after a sixth read");
   chk_rsp_pulse:
   assert property (rsp_valid |=> !rsp_valid)
      else $error("read pulse longer than one cycle");
endmodule // nvsq_host_chk
bind nvsq_host nvsq_host_chk u_chk (.clk_sys(clk_sys), .rst(rst), .rsp_valid(rsp_valid),
   .busy(busy), .save_refused(save_refused), .cs_n(cs_n), .update_n(update_n),
   .oe_n(oe_n), .addr(addr), .dq_oe(dq_oe));

// [verif/nvsq_sram_model.sv]
`timescale 1ns/1ps
module nvsq_sram_model (
   input wire logic cs_n, // select
   input wire logic update_n, // write strobe
   input wire logic oe_n, // output gate
   input wire logic [10:0] addr, // address
   input wire logic [7:0] dq_o, // host data
   input wire logic supply_ok, // supply state
   output logic [7:0] dq_i, // device data
   output int saves, // saves done
   output int loads // loads done
);
   logic [7:0] mem [2048];
   logic [7:0] nv [2048];
   logic [7:0] last = 8'h00;
   logic hz = 1'b0;
   logic busy_m = 1'b0;
   int step = 0;
   logic [10:0] seq [5] = '{nvsq_pkg::SEQ_A0, nvsq_pkg::SEQ_A1, nvsq_pkg::SEQ_A2,
      nvsq_pkg::SEQ_A3, nvsq_pkg::SEQ_A4};
   initial saves = 0;
   initial loads = 0;
   // floating data
   // released bus shows inverse of last byte, never a held value
   assign dq_i = (!cs_n && update_n && !oe_n && !hz && !busy_m) ? mem[addr] : ~last;
   always @(posedge cs_n) begin
      last <= dq_i;
      if (!update_n && !busy_m) mem[addr] = dq_o;
   end
   always @(negedge cs_n) begin
      hz = !update_n;
      if (!busy_m && !update_n) step = 0;
      else if (!busy_m && step == 5 && addr[10:1] == 10'h387) begin
         hz = 1'b1;
         step = 0;
         busy_m = 1'b1;
         if (addr[0] && supply_ok) begin
            nv = mem;
            saves++;
         end else if (!addr[0]) begin
            foreach (mem[i]) mem[i] = 8'h00;
            mem = nv;
            loads++;
         end
         #500 busy_m = 1'b0;
      end else if (!busy_m)
         step = (addr == seq[step]) ? step + 1 : (addr == seq[0]) ? 1 : 0;
   end
endmodule // nvsq_sram_model

// [verif/nvsq_host_test.sv]
`timescale 1ns/1ps
module nvsq_host_test;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic [1:0] req_cmd = 2'h0;
   logic [10:0] req_addr = 11'h000;
   logic [7:0] req_wdata = 8'h00;
   logic supply_ok = 1'b1;
   logic req_ready, rsp_valid, busy, save_refused, cs_n, update_n, oe_n, dq_oe;
   logic [10:0] addr;
   logic [7:0] rsp_rdata, dq_o, dq_i;
   int saves, loads, fails = 0, samples_checked = 0;
   always #10 clk_sys = ~clk_sys;
   nvsq_host #(.SAVE_CLKS(50), .BOOT_CLKS(20)) u_nvsq_host (.clk_sys(clk_sys), .rst(rst),
      .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata),
      .supply_ok(supply_ok), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .busy(busy), .save_refused(save_refused), .cs_n(cs_n),
      .update_n(update_n), .oe_n(oe_n), .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
   nvsq_sram_model u_nvsq_sram_model (.cs_n(cs_n), .update_n(update_n), .oe_n(oe_n),
      .addr(addr), .dq_o(dq_o), .supply_ok(supply_ok), .dq_i(dq_i), .saves(saves), .loads(loads));
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         fails++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   // a request is offered at an edge where ready was seen high, or after 2000 cycles without it
   task automatic req(input logic [1:0] c, input logic [10:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      while (req_ready !== 1'b1 && n < 2000) begin
         @(posedge clk_sys);
         n++;
      end
      req_valid <= 1'b1;
      req_cmd <= c;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clk_sys);
      req_valid <= 1'b0;
   endtask
   task automatic rd(input logic [10:0] a, input logic [7:0] e);
      int n;
      n = 0;
      req(2'h0, a, 8'h00);
      while (rsp_valid !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      chk(rsp_valid === 1'b1 && rsp_rdata === e, "read data");
   endtask
   task automatic wait_busy(input logic v, input int lim);
      int n;
      n = 0;
      while (busy !== v && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      chk(busy === v, "busy level");
   endtask
   task automatic t_boot;
      chk(busy === 1'b1 && req_ready === 1'b0, "boot busy");
      wait_busy(1'b0, 40);
      $display("test boot done");
   endtask
   task automatic t_rw;
      req(2'h1, nvsq_pkg::SEQ_A1, 8'ha5);
      req(2'h1, 11'h123, 8'h3c);
      rd(nvsq_pkg::SEQ_A1, 8'ha5);
      rd(11'h123, 8'h3c);
      $display("test read write done");
   endtask
   task automatic t_save_load;
      req(2'h2, 11'h000, 8'h00);
      wait_busy(1'b1, 100);
      chk(saves === 1, "save count");
      wait_busy(1'b0, 100);
      req(2'h1, 11'h123, 8'hc3);
      rd(11'h123, 8'hc3);
      req(2'h3, 11'h000, 8'h00);
      wait_busy(1'b1, 100);
      chk(loads === 1 && saves === 1, "load count");
      wait_busy(1'b0, 1100);
      rd(11'h123, 8'h3c);
      $display("test save load done");
   endtask
   task automatic t_refuse;
      int n;
      n = 0;
      supply_ok <= 1'b0;
      repeat (4) @(posedge clk_sys);
      req(2'h2, 11'h000, 8'h00);
      while (save_refused !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      chk(save_refused === 1'b1 && saves === 1, "low supply save");
      supply_ok <= 1'b1;
      $display("test refuse done");
   endtask
   task automatic results;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_boot;
      t_rw;
      t_save_load;
      t_refuse;
      results;
   end
   // whole run needs under 1500 cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      results;
   end
endmodule // nvsq_host_test
